/* File: eiix_addr_resolve.sv */
// module: resolves an operand address for standard byte/bit opcodes,
// with or without indexed literal offset addressing.
// assumes: combinational use by the executor; bank select supplied.
module eiix_addr_resolve (
    // opcode fields
    input  wire logic [7:0]  i_file,
    input  wire logic        i_access,
    // core state
    input  wire logic        i_ext_en,
    input  wire logic [3:0]  i_bank_select_register,
    input  wire logic [11:0] i_software_stack_pointer,
    // result
    output logic      [11:0] o_addr,
    output logic             o_indexed
);
    always_comb begin
        o_indexed = 1'b0;
        if (!i_access && i_ext_en && i_file <= eiix_pkg::IDX_LIMIT) begin
            o_indexed = 1'b1;
            // pointer zero gives file itself, the legacy low bank
            o_addr = i_software_stack_pointer + {4'h0, i_file};
        end else if (!i_access) begin
            o_addr = (i_file < eiix_pkg::ACCESS_SPLIT)
                   ? {eiix_pkg::ACCESS_LOW_BANK, i_file}
                   : {eiix_pkg::SFR_BANK, i_file};
        end else begin
            o_addr = {i_bank_select_register, i_file};
        end
    end
endmodule

/* File: eiix_exec.sv */
// module: executes the indexed move, literal push, pointer subtract
// and subtract-and-return, and resolves standard operand addresses.
// assumes: one opcode per instruction cycle, given with i_instr_valid;
// data memory reads return in the same cycle (combinational).
module eiix_exec (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // configuration
    input  wire logic        i_extension_enable_config_bit,
    // instruction stream
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_opcode,
    // core state
    input  wire logic [3:0]  i_bank_select_register,
    input  wire logic [20:0] i_return_stack_top,
    input  wire logic [7:0]  i_mem_rdata,
    // standard operand resolution
    output logic      [11:0] o_std_addr,
    output logic             o_std_indexed,
    output logic             o_std_dest_file,
    // data memory
    output logic      [11:0] o_mem_raddr,
    output logic             o_mem_we,
    output logic      [11:0] o_mem_waddr,
    output logic      [7:0]  o_mem_wdata,
    // pointers and flow
    output logic      [11:0] o_ptr0,
    output logic      [11:0] o_ptr1,
    output logic      [11:0] o_software_stack_pointer,
    output logic             o_pc_load,
    output logic      [20:0] o_pc_value,
    output logic             o_busy,
    output logic             o_ext_en
);
    logic [1:0] rst_sync_q;
    logic       rst_b;
    logic       ext_en_q, ext_en_d, ext_latched_q;
    eiix_pkg::eiix_state_t state_q, state_d;
    logic [11:0] ptr_q [3], ptr_d [3];
    logic [7:0]  move_data_q, move_data_d;
    logic        we_q, we_d;
    logic [11:0] waddr_q, waddr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        pcl_q, pcl_d;
    logic [20:0] pcv_q, pcv_d;
    logic [11:0] src_addr, dst_addr;
    logic        src_ind, dst_ind;
    logic [1:0]  psel;
    logic [11:0] lit6;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // ---------------------------------------------------------------
    // standard operand address
    // ---------------------------------------------------------------
    eiix_addr_resolve u_resolve (
        .i_file                   (i_opcode[eiix_pkg::FILE_W-1:0]),
        .i_access                 (i_opcode[eiix_pkg::ACCESS_BIT]),
        .i_ext_en                 (ext_en_q),
        .i_bank_select_register   (i_bank_select_register),
        .i_software_stack_pointer (ptr_q[2]),
        .o_addr                   (o_std_addr),
        .o_indexed                (o_std_indexed)
    );
    assign o_std_dest_file = i_opcode[eiix_pkg::DEST_BIT];

    // ---------------------------------------------------------------
    // indexed move address and indirect detection
    // ---------------------------------------------------------------
    function automatic logic is_indirect(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < eiix_pkg::IND_PORTS; i++) begin
            if (a == eiix_pkg::INDF0_ADDR - 12'(i) ||
                a == eiix_pkg::INDF1_ADDR - 12'(i) ||
                a == eiix_pkg::INDF2_ADDR - 12'(i)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // full 12-bit space, carry dropped
    assign src_addr = ptr_q[2] + {5'h00, i_opcode[eiix_pkg::OFS7_W-1:0]};
    assign dst_addr = ptr_q[2] + {5'h00, i_opcode[eiix_pkg::OFS7_W-1:0]};
    assign src_ind  = is_indirect(src_addr);
    assign dst_ind  = is_indirect(dst_addr);
    assign psel     = i_opcode[eiix_pkg::PSEL_LSB +: 2];
    assign lit6     = {6'h00, i_opcode[eiix_pkg::LIT6_W-1:0]};
    assign o_mem_raddr = src_addr;

    // ---------------------------------------------------------------
    // extension enable, caught once after reset release
    // ---------------------------------------------------------------
    always_comb begin
        ext_en_d = ext_en_q;
        if (!ext_latched_q) begin
            ext_en_d = i_extension_enable_config_bit;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_en_q      <= eiix_pkg::EXT_ENABLE_DEFAULT;
            ext_latched_q <= 1'b0;
        end else begin
            ext_en_q      <= ext_en_d;
            ext_latched_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // executor
    // ---------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        ptr_d       = ptr_q;
        move_data_d = move_data_q;
        we_d        = 1'b0;
        waddr_d     = waddr_q;
        wdata_d     = wdata_q;
        pcl_d       = 1'b0;
        pcv_d       = pcv_q;
        case (state_q)
            eiix_pkg::EIIX_IDLE: begin
                if (i_instr_valid && ext_en_q) begin
                    if (i_opcode[15:8] == eiix_pkg::OPC_MOVE_IDX_HI &&
                        i_opcode[eiix_pkg::MOVE_FLAG_BIT]) begin
                        move_data_d = src_ind ? 8'h00 : i_mem_rdata;
                        state_d     = eiix_pkg::EIIX_MOVE_DST;
                    end else if (i_opcode[15:8] ==
                                 eiix_pkg::OPC_PUSH_LIT_HI) begin
                        we_d     = 1'b1;
                        waddr_d  = ptr_q[2];
                        wdata_d  = i_opcode[7:0];
                        ptr_d[2] = ptr_q[2] - 12'h001;
                    end else if (i_opcode[15:8] ==
                                 eiix_pkg::OPC_SUB_PTR_HI) begin
                        if (psel == eiix_pkg::PSEL_RETURN) begin
                            ptr_d[2] = ptr_q[2] - lit6;
                            pcl_d    = 1'b1;
                            pcv_d    = i_return_stack_top;
                            state_d  = eiix_pkg::EIIX_RET_NOP;
                        end else begin
                            ptr_d[psel] = ptr_q[psel] - lit6;
                        end
                    end
                end
            end
            eiix_pkg::EIIX_MOVE_DST: begin
                if (i_instr_valid) begin
                    // software keeps pc low and return top out of reach
                    if (!dst_ind) begin
                        we_d    = 1'b1;
                        waddr_d = dst_addr;
                        wdata_d = move_data_q;
                    end
                    state_d = eiix_pkg::EIIX_IDLE;
                end
            end
            eiix_pkg::EIIX_RET_NOP: begin
                // flushed fetch cycle, nothing executes
                if (i_instr_valid) begin
                    state_d = eiix_pkg::EIIX_IDLE;
                end
            end
            default: begin
                state_d = eiix_pkg::EIIX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q     <= eiix_pkg::EIIX_IDLE;
            ptr_q[0]    <= eiix_pkg::STACK_PTR_RESET;
            ptr_q[1]    <= eiix_pkg::STACK_PTR_RESET;
            ptr_q[2]    <= eiix_pkg::STACK_PTR_RESET;
            move_data_q <= 8'h00;
            we_q        <= 1'b0;
            waddr_q     <= 12'h000;
            wdata_q     <= 8'h00;
            pcl_q       <= 1'b0;
            pcv_q       <= 21'h0;
        end else begin
            state_q     <= state_d;
            ptr_q       <= ptr_d;
            move_data_q <= move_data_d;
            we_q        <= we_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
            pcl_q       <= pcl_d;
            pcv_q       <= pcv_d;
        end
    end

    assign o_mem_we    = we_q;
    assign o_mem_waddr = waddr_q;
    assign o_mem_wdata = wdata_q;
    assign o_ptr0      = ptr_q[0];
    assign o_ptr1      = ptr_q[1];
    assign o_software_stack_pointer = ptr_q[2];
    assign o_pc_load   = pcl_q;
    assign o_pc_value  = pcv_q;
    assign o_busy      = (state_q != eiix_pkg::EIIX_IDLE);
    assign o_ext_en    = ext_en_q;
endmodule

/* File: eiix_exec_bench.sv */
// bench: drives the executor and compares with an integer model
// assumes: eiix_pkg, eiix_exec and the checker compiled first
module eiix_exec_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_extension_enable_config_bit = 1'b0;
    logic        i_instr_valid = 1'b0;
    logic [15:0] i_opcode = 16'h0000;
    logic [3:0]  i_bank_select_register = 4'h0;
    logic [20:0] i_return_stack_top = 21'h0;
    logic [7:0]  i_mem_rdata;
    logic [11:0] o_std_addr, o_mem_raddr, o_mem_waddr;
    logic [11:0] o_ptr0, o_ptr1, o_software_stack_pointer;
    logic [7:0]  o_mem_wdata;
    logic [20:0] o_pc_value;
    logic        o_std_indexed, o_std_dest_file, o_mem_we;
    logic        o_pc_load, o_busy, o_ext_en;
    logic [7:0]  mem [4096];
    int          p [3];
    // pc low and first return-top byte; plain defaults, not checked
    localparam logic [11:0] PC_LOW_ADDR  = 12'hff9;
    localparam logic [11:0] RET_TOP_ADDR = 12'hffd;
    int          n_fail = 0;
    int          n_tests = 0;
    eiix_exec eiix_exec_i (.*);
    always #2.5 i_clk = ~i_clk;
    assign i_mem_rdata = mem[o_mem_raddr];
    always @(posedge i_clk) if (o_mem_we === 1'b1) mem[o_mem_waddr] <= o_mem_wdata;
    // ---
    // tasks
    // ---
    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic send(input logic [15:0] op);
        i_instr_valid <= 1'b1;
        i_opcode <= op;
        @(posedge i_clk);
        #1;
    endtask
    task automatic idle();
        i_instr_valid <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask
    task automatic do_reset(input logic en);
        i_rst_b <= 1'b0;
        i_instr_valid <= 1'b0;
        i_extension_enable_config_bit <= en;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        p = '{0, 0, 0};
    endtask
    task automatic chk_ptr();
        chk("ptr0", p[0], o_ptr0);
        chk("ptr1", p[1], o_ptr1);
        chk("sp", p[2], o_software_stack_pointer);
    endtask
    task automatic sub(input logic [1:0] f);
        logic [5:0] k;
        k = 6'($urandom);
        send({8'he9, f, k});
        p[f == 2'h3 ? 2 : f] = (p[f == 2'h3 ? 2 : f] - k) & 'hfff;
        chk_ptr();
    endtask
    task automatic push(input logic [7:0] k);
        send({8'hfa, k});
        chk("we", 1'b1, o_mem_we);
        chk("waddr", p[2], o_mem_waddr);
        chk("wdata", k, o_mem_wdata);
        p[2] = (p[2] - 1) & 'hfff;
        chk_ptr();
    endtask
    function automatic logic ind(input logic [11:0] a);
        int b;
        ind = 1'b0;
        for (int i = 0; i < 3; i++) begin
            b = 'hfef - 8 * i;
            if (a <= b && a > b - eiix_pkg::IND_PORTS) ind = 1'b1;
        end
    endfunction
    task automatic move(input logic [6:0] zs, input logic [6:0] zd);
        logic [11:0] s, d;
        logic [7:0]  v;
        s = 12'(p[2] + zs);
        d = 12'(p[2] + zd);
        v = ind(s) ? 8'h00 : mem[s];
        if (d == PC_LOW_ADDR || d >= RET_TOP_ADDR) return;
        send({8'heb, 1'b1, zs});
        send({8'hf0, 1'b0, zd});
        chk("move_we", !ind(d), o_mem_we);
        if (!ind(d)) chk("move_waddr", d, o_mem_waddr);
        if (!ind(d)) chk("move_wdata", v, o_mem_wdata);
    endtask
    task automatic std_chk(input logic en);
        logic [15:0] op;
        logic [3:0]  bs;
        logic        x;
        // no opcode may be taken while addresses are probed
        i_instr_valid <= 1'b0;
        repeat (24) begin
            op = 16'($urandom);
            bs = 4'($urandom);
            i_opcode <= op;
            i_bank_select_register <= bs;
            #1;
            x = en && !op[8] && op[7:0] <= 8'h5f;
            chk("std_idx", x, o_std_indexed);
            chk("std_addr", x ? 12'(p[2] + op[7:0]) : {op[8] ? bs
                : (op[7:0] > 8'h5f ? 4'hf : 4'h0), op[7:0]}, o_std_addr);
            chk("std_dest", op[9], o_std_dest_file);
            @(posedge i_clk);
            #1;
        end
    endtask
    initial begin
        #100us;
        n_fail++;
        test_done();
    end
    // ---
    // main sequence
    // ---
    initial begin
        void'($urandom(8948));
        foreach (mem[i]) mem[i] = 8'($urandom);
        do_reset(1'b0);
        chk("ext_en", 1'b0, o_ext_en);
        std_chk(1'b0);
        send(16'hfa55);
        chk("we_off", 1'b0, o_mem_we);
        chk_ptr();
        do_reset(1'b1);
        chk("ext_en", 1'b1, o_ext_en);
        std_chk(1'b1);
        for (int f = 0; f < 3; f++) sub(2'(f));
        std_chk(1'b1);
        i_return_stack_top <= 21'($urandom);
        sub(2'h3);
        chk("pc_load", 1'b1, o_pc_load);
        chk("pc_value", i_return_stack_top, o_pc_value);
        chk("busy", 1'b1, o_busy);
        send(16'hfa77);
        chk("nop_load", 1'b0, o_pc_load);
        chk("nop_we", 1'b0, o_mem_we);
        chk_ptr();
        push(8'h08);
        push(8'hff);
        do_reset(1'b1);
        send(16'he9a0);
        p[2] = 'hfe0;
        move(7'h0f, 7'h10);
        move(7'h7f, 7'h05);
        move(7'h10, 7'h20);
        repeat (6) move(7'($urandom), 7'($urandom));
        idle();
        test_done();
    end
endmodule

/* File: eiix_exec_properties.sv */
// checker: port properties of the indexed instruction executor
// assumes: bound into eiix_exec, one clock domain
module eiix_exec_chk (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    // stimulus
    input wire logic        i_instr_valid,
    input wire logic [15:0] i_opcode,
    input wire logic [3:0]  i_bank_select_register,
    input wire logic [20:0] i_return_stack_top,
    // results
    input wire logic [11:0] o_std_addr,
    input wire logic        o_std_indexed,
    input wire logic [11:0] o_mem_raddr,
    input wire logic        o_mem_we,
    input wire logic [11:0] o_mem_waddr,
    input wire logic [7:0]  o_mem_wdata,
    input wire logic [11:0] o_ptr0,
    input wire logic [11:0] o_software_stack_pointer,
    input wire logic        o_pc_load,
    input wire logic [20:0] o_pc_value,
    input wire logic        o_busy,
    input wire logic        o_ext_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire        go = i_instr_valid && !o_busy && o_ext_en;
    wire [7:0]  hi = i_opcode[15:8];
    wire [11:0] sp = o_software_stack_pointer;
    wire        ix = o_ext_en && !i_opcode[8] && i_opcode[7:0] <= 8'h5f;
    sequence s_move;
        go && hi == 8'heb ##1 i_instr_valid;
    endsequence
    property p_push;
        go && hi == 8'hfa |=> o_mem_we && o_mem_waddr == $past(sp)
            && o_mem_wdata == $past(i_opcode[7:0])
            && sp == 12'($past(sp) - 12'h001);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");
    property p_sub;
        go && hi == 8'he9 && i_opcode[7:6] == 2'h0
            |=> o_ptr0 == $past(o_ptr0) - $past(i_opcode[5:0]);
    endproperty
    a_sub: assert property (p_sub) else $error("sub wrong");
    property p_ret;
        go && hi == 8'he9 && i_opcode[7:6] == 2'h3 |=> o_pc_load && o_busy
            && o_pc_value == $past(i_return_stack_top)
            && sp == $past(sp) - $past(i_opcode[5:0]);
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_ret_nop;
        o_pc_load |=> !o_pc_load && !o_busy && !o_mem_we && $stable(sp);
    endproperty
    a_ret_nop: assert property (p_ret_nop) else $error("nop wrong");
    property p_move_src;
        go && hi == 8'heb |-> o_mem_raddr == sp + i_opcode[6:0];
    endproperty
    a_move_src: assert property (p_move_src) else $error("src");
    property p_move_dst;
        s_move |=> !o_mem_we
            || o_mem_waddr == $past(sp) + $past(i_opcode[6:0]);
    endproperty
    a_move_dst: assert property (p_move_dst) else $error("dst");
    property p_std_idx;
        ix |-> o_std_indexed && o_std_addr == sp + i_opcode[7:0];
    endproperty
    a_std_idx: assert property (p_std_idx) else $error("idx");
    property p_std_abs;
        !ix |-> !o_std_indexed && o_std_addr == {i_opcode[8]
            ? i_bank_select_register
            : (i_opcode[7:0] > 8'h5f ? 4'hf : 4'h0), i_opcode[7:0]};
    endproperty
    a_std_abs: assert property (p_std_abs) else $error("abs");
    property p_off;
        !o_ext_en |=> !o_mem_we && !o_pc_load && $stable(sp);
    endproperty
    a_off: assert property (p_off) else $error("ext off");
    c_push: cover property (go && hi == 8'hfa);
    c_ret: cover property (o_pc_load);
    c_idx: cover property (o_std_indexed);
endmodule
bind eiix_exec eiix_exec_chk eiix_exec_chk_i (.*);

/* File: eiix_pkg.sv */
// package: encodings, address constants and field layout for the
// extended indexed instruction executor.
// assumes: 8-bit core, 12-bit data address space, 16-bit opcodes.
//
// How it works
// - two-word indexed move, offsets plus stack pointer
// - both move addresses span full data space
// - indirect register as move source reads zero
// - indirect register as move destination: no-op
// - push literal at pointer, then decrement pointer
// - subtract 6-bit literal from selected pointer
// - select 11: subtract from stack pointer, return
// - subtract-and-return takes two cycles, second idle
// - extension enable also enables indexed addressing
// - disabled: access bank or bank-select address
// - enabled, access 0, file <= 5fh: pointer-relative
// - larger file addresses resolve as standard
// - pointer zero restores legacy access bank map
// - indexed form treats access bit as zero
// - destination-select bit keeps standard meaning
// - config bit defaults zero, extension disabled
package eiix_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int OPC_W  = 16;

    // opcode high bytes
    localparam logic [7:0] OPC_MOVE_IDX_HI = 8'heb;
    localparam logic [7:0] OPC_PUSH_LIT_HI = 8'hfa;
    localparam logic [7:0] OPC_SUB_PTR_HI  = 8'he9;
    localparam logic [3:0] OPC_SECOND_NIB  = 4'hf;
    localparam int         MOVE_FLAG_BIT   = 7;

    // field layout
    localparam int OFS7_W     = 7;
    localparam int LIT6_W     = 6;
    localparam int PSEL_LSB   = 6;
    localparam logic [1:0] PSEL_RETURN = 2'h3;
    localparam int ACCESS_BIT = 8;
    localparam int DEST_BIT   = 9;
    localparam int FILE_W     = 8;

    // addressing
    localparam logic [7:0] IDX_LIMIT       = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
    localparam logic [3:0] SFR_BANK        = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [ADDR_W-1:0] STACK_PTR_RESET = 12'h000;

    // indirect operand registers (three pointers, five ports each)
    localparam logic [ADDR_W-1:0] INDF0_ADDR = 12'hfef;
    localparam logic [ADDR_W-1:0] INDF1_ADDR = 12'hfe7;
    localparam logic [ADDR_W-1:0] INDF2_ADDR = 12'hfdf;
    localparam int IND_PORTS = 5;

    localparam logic [0:0] EXT_ENABLE_DEFAULT = 1'h0;

    typedef enum logic [1:0] {
        EIIX_IDLE,
        EIIX_MOVE_DST,
        EIIX_RET_NOP
    } eiix_state_t;

endpackage
